/* File: rtl/bmwd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bmwd_params.svh"

// How it works
// - memory window start field, bits 15:4
// - memory window end field, low bits ones
// - memory reserved nibble reads zero, ignores writes
// - prefetch window start field, bits 15:4
// - prefetch window end field, low bits ones
// - prefetch low nibble reads one, read-only
// - prefetch start upper half at 28h
// - prefetch end upper half at 2Ch
// - memory start at 20h, resets zero
// - memory end at 22h; hits forward
// - prefetch start/end at 24h/26h, reset 0001h
module bmwd_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire bmwd_pkg::bmwd_cfg_addr_type cfgAddr,
    input wire bmwd_pkg::bmwd_word_type cfgWrData,
    input wire bmwd_pkg::bmwd_be_type cfgByteEn,
    output bmwd_pkg::bmwd_word_type cfgRdData,
    output logic cfgRdValid,
    input wire logic txnValid,
    input wire bmwd_pkg::bmwd_addr_type txnAddr,
    output logic fwdValid,
    output logic fwdMemHit,
    output logic fwdPrefHit
);
    import bmwd_pkg::*;

    bmwd_field_type memoryWindowLowField_r;
    bmwd_field_type memoryWindowHighField_r;
    bmwd_field_type prefetchWindowLowField_r;
    bmwd_field_type prefetchWindowHighField_r;
    bmwd_word_type prefUpStart;
    bmwd_word_type prefUpEnd;
    bmwd_word_type memWord;
    bmwd_word_type prefWord;
    bmwd_word_type memWordNew;
    bmwd_word_type prefWordNew;
    bmwd_word_type rdData_nxt;
    bmwd_word_type cfgRdData_r;
    logic cfgRdValid_r;
    logic fwdValid_r;
    logic fwdMemHit_r;
    logic fwdPrefHit_r;
    bmwd_addr_type memLow;
    bmwd_addr_type memHigh;
    bmwd_addr_type prefLow;
    bmwd_addr_type prefHigh;
    logic memHit;
    logic prefHit;
    logic wrMem;
    logic wrPref;

    // reserved nibbles are rebuilt as zero on every read
    // wide addressing indicator is a constant
    assign memWord = {memoryWindowHighField_r, `BMWD_RESERVED_FIELD_VAL,
                      memoryWindowLowField_r, `BMWD_RESERVED_FIELD_VAL};
    assign prefWord = {prefetchWindowHighField_r, `BMWD_WIDE_IND,
                       prefetchWindowLowField_r, `BMWD_WIDE_IND};

    // 20h/22h and 24h/26h share one dword each; lanes pick the half
    assign wrMem = cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_MEM_START);
    assign wrPref = cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_START);
    assign memWordNew = bmwd_merge(memWord, cfgWrData, cfgByteEn);
    assign prefWordNew = bmwd_merge(prefWord, cfgWrData, cfgByteEn);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memoryWindowLowField_r <= bmwd_field_type'(`BMWD_MEM_RST >> `BMWD_FIELD_LSB);
        end else if (wrMem) begin
            memoryWindowLowField_r <= memWordNew[15:4];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            memoryWindowHighField_r <= bmwd_field_type'(`BMWD_MEM_RST >> `BMWD_FIELD_LSB);
        end else if (wrMem) begin
            memoryWindowHighField_r <= memWordNew[31:20];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prefetchWindowLowField_r <= bmwd_field_type'(`BMWD_PREF_RST >> `BMWD_FIELD_LSB);
        end else if (wrPref) begin
            prefetchWindowLowField_r <= prefWordNew[15:4];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prefetchWindowHighField_r <= bmwd_field_type'(`BMWD_PREF_RST >> `BMWD_FIELD_LSB);
        end else if (wrPref) begin
            prefetchWindowHighField_r <= prefWordNew[31:20];
        end
    end

    bmwd_upper_reg #(
        .OFS(`BMWD_OFS_PREF_UP_START),
        .RST(`BMWD_UP_RST)
    ) uUpStart (
        .clk(clk),
        .rst_b(rst_b),
        .cfgWrEn(cfgWrEn),
        .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData),
        .cfgByteEn(cfgByteEn),
        .value(prefUpStart)
    );

    bmwd_upper_reg #(
        .OFS(`BMWD_OFS_PREF_UP_END),
        .RST(`BMWD_UP_RST)
    ) uUpEnd (
        .clk(clk),
        .rst_b(rst_b),
        .cfgWrEn(cfgWrEn),
        .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData),
        .cfgByteEn(cfgByteEn),
        .value(prefUpEnd)
    );

    // unmapped dwords read zero, which keeps probing software harmless
    always_comb begin
        rdData_nxt = '0;
        if (bmwd_dword_hit(cfgAddr, `BMWD_OFS_MEM_START)) begin
            rdData_nxt = memWord;
        end else if (bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_START)) begin
            rdData_nxt = prefWord;
        end else if (bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_UP_START)) begin
            rdData_nxt = prefUpStart;
        end else if (bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_UP_END)) begin
            rdData_nxt = prefUpEnd;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgRdData_r <= '0;
            cfgRdValid_r <= 1'b0;
        end else begin
            cfgRdValid_r <= cfgRdEn;
            if (cfgRdEn) begin
                cfgRdData_r <= rdData_nxt;
            end
        end
    end

    // start padded with zeros below bit 20
    // end padded with ones below bit 20
    assign memLow = {32'h0000_0000, memoryWindowLowField_r, `BMWD_LOW_FILL};
    assign memHigh = {32'h0000_0000, memoryWindowHighField_r, `BMWD_HIGH_FILL};
    assign prefLow = {prefUpStart, prefetchWindowLowField_r, `BMWD_LOW_FILL};
    assign prefHigh = {prefUpEnd, prefetchWindowHighField_r, `BMWD_HIGH_FILL};

    bmwd_window_cmp #(.W(64)) uMemCmp (
        .lowBound(memLow),
        .highBound(memHigh),
        .addr(txnAddr),
        .hit(memHit)
    );

    bmwd_window_cmp #(.W(64)) uPrefCmp (
        .lowBound(prefLow),
        .highBound(prefHigh),
        .addr(txnAddr),
        .hit(prefHit)
    );

    // forwarding decision, registered one cycle later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fwdValid_r <= 1'b0;
            fwdMemHit_r <= 1'b0;
            fwdPrefHit_r <= 1'b0;
        end else begin
            fwdValid_r <= txnValid;
            fwdMemHit_r <= txnValid && memHit;
            fwdPrefHit_r <= txnValid && prefHit;
        end
    end

    assign cfgRdData = cfgRdData_r;
    assign cfgRdValid = cfgRdValid_r;
    assign fwdValid = fwdValid_r;
    assign fwdMemHit = fwdMemHit_r;
    assign fwdPrefHit = fwdPrefHit_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_rd_latency: assert property (cfgRdEn |=> cfgRdValid)
        else $error("read answer missing");
    a_mem_reserved_field_zero: assert property (
        cfgRdEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_MEM_START)
        |=> cfgRdData[3:0] == 4'h0 && cfgRdData[19:16] == 4'h0)
        else $error("memory reserved bits not zero");
    a_pref_wide_ind: assert property (
        cfgRdEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_START)
        |=> cfgRdData[3:0] == 4'h1 && cfgRdData[19:16] == 4'h1)
        else $error("wide indicator wrong");
    a_mem_start_wr: assert property (
        cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_MEM_START) && cfgByteEn == 4'hf
        |=> memoryWindowLowField_r == $past(cfgWrData[15:4]))
        else $error("memory start not written");
    a_mem_end_wr: assert property (
        cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_MEM_END) && cfgByteEn == 4'hc
        |=> memoryWindowHighField_r == $past(cfgWrData[31:20])
            && memoryWindowLowField_r == $past(memoryWindowLowField_r))
        else $error("memory end lane write wrong");
    a_pref_fields_wr: assert property (
        cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_START) && cfgByteEn == 4'hf
        |=> prefetchWindowLowField_r == $past(cfgWrData[15:4])
            && prefetchWindowHighField_r == $past(cfgWrData[31:20]))
        else $error("prefetch fields not written");
    a_mem_hit_bound: assert property (
        txnValid && txnAddr[63:32] == 32'h0
        && txnAddr[31:20] >= memoryWindowLowField_r
        && txnAddr[31:20] <= memoryWindowHighField_r
        |=> fwdValid && fwdMemHit)
        else $error("memory window hit lost");
    a_closed_window: assert property (
        txnValid && memoryWindowLowField_r > memoryWindowHighField_r |=> !fwdMemHit)
        else $error("closed window forwarded");
    a_pref_upper: assert property (
        txnValid && txnAddr[63:32] < prefUpStart |=> !fwdPrefHit)
        else $error("prefetch hit below upper start");
    a_pref_end_upper: assert property (
        txnValid && txnAddr[63:32] > prefUpEnd |=> !fwdPrefHit)
        else $error("prefetch hit above upper end");
    // sampled before the release edge updates, so a first-cycle write is not seen yet
    a_pref_reset_read: assert property (
        $rose(rst_b) |-> prefWord == {`BMWD_PREF_RST, `BMWD_PREF_RST})
        else $error("prefetch reset value wrong");
    a_mem_reset_read: assert property (
        $rose(rst_b) |-> memWord == {`BMWD_MEM_RST, `BMWD_MEM_RST})
        else $error("memory reset value wrong");
    a_pref_hit_bound: assert property (
        txnValid && txnAddr >= prefLow && txnAddr <= prefHigh |=> fwdPrefHit)
        else $error("prefetch window hit lost");
    a_pref_end_wr: assert property (
        cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_END) && cfgByteEn == 4'hc
        |=> prefetchWindowHighField_r == $past(cfgWrData[31:20])
            && prefetchWindowLowField_r == $past(prefetchWindowLowField_r))
        else $error("prefetch end lane write wrong");
    a_up_start_wr: assert property (
        cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_UP_START) && cfgByteEn == 4'hf
        |=> prefUpStart == $past(cfgWrData))
        else $error("upper start not written");
    a_up_end_wr: assert property (
        cfgWrEn && bmwd_dword_hit(cfgAddr, `BMWD_OFS_PREF_UP_END) && cfgByteEn == 4'hf
        |=> prefUpEnd == $past(cfgWrData))
        else $error("upper end not written");
    // decode checks use the register image of the taking edge
    a_mem_upper_miss: assert property (
        txnValid && txnAddr[63:32] != 32'h0 |=> !fwdMemHit)
        else $error("wide address hit memory window");
    a_idle_no_fwd: assert property (
        !txnValid |=> !fwdValid && !fwdMemHit && !fwdPrefHit)
        else $error("forward without transaction");
    a_mem_below_start: assert property (
        txnValid && txnAddr[31:20] < memoryWindowLowField_r |=> !fwdMemHit)
        else $error("hit below memory start");
    a_mem_above_end: assert property (
        txnValid && txnAddr[31:20] > memoryWindowHighField_r |=> !fwdMemHit)
        else $error("hit above memory end");
    a_pref_below_start: assert property (
        txnValid && txnAddr < prefLow |=> !fwdPrefHit)
        else $error("hit below prefetch start");
    // read data stands until the next read strobe
    a_rd_hold: assert property (
        !cfgRdEn |=> $stable(cfgRdData))
        else $error("read data changed without read");
    a_rd_no_extra: assert property (
        !cfgRdEn |=> !cfgRdValid)
        else $error("read answer without request");

    c_mem_forward: cover property (txnValid ##1 fwdMemHit);
    c_pref_forward: cover property (txnValid ##1 fwdPrefHit);
    c_cfg_write_read: cover property (wrMem ##[1:2] cfgRdEn ##1 cfgRdValid);
    c_miss_both: cover property (fwdValid && !fwdMemHit && !fwdPrefHit);
    c_closed_txn: cover property (txnValid && memoryWindowLowField_r > memoryWindowHighField_r);
endmodule

`default_nettype wire

/* File: include/bmwd_params.svh */
`ifndef BMWD_PARAMS_SVH
`define BMWD_PARAMS_SVH

`define BMWD_OFS_MEM_START 8'h20
`define BMWD_OFS_MEM_END 8'h22
`define BMWD_OFS_PREF_START 8'h24
`define BMWD_OFS_PREF_END 8'h26
`define BMWD_OFS_PREF_UP_START 8'h28
`define BMWD_OFS_PREF_UP_END 8'h2c

`define BMWD_FIELD_LSB 4
`define BMWD_FIELD_MSB 15
`define BMWD_MEM_RST 16'h0000
`define BMWD_PREF_RST 16'h0001
`define BMWD_UP_RST 32'h0000_0000
`define BMWD_RESERVED_FIELD_VAL 4'h0
`define BMWD_WIDE_IND 4'h1
`define BMWD_LOW_FILL 20'h00000
`define BMWD_HIGH_FILL 20'hfffff
`define BMWD_RD_LATENCY 1

`endif

/* File: include/bmwd_pkg.sv */
package bmwd_pkg;

    typedef logic [11:0] bmwd_field_type;
    typedef logic [31:0] bmwd_word_type;
    typedef logic [63:0] bmwd_addr_type;
    typedef logic [3:0] bmwd_be_type;
    typedef logic [7:0] bmwd_cfg_addr_type;

    // byte-lane merge of a configuration write into an old dword
    function automatic bmwd_word_type bmwd_merge(
        input bmwd_word_type oldVal,
        input bmwd_word_type newVal,
        input bmwd_be_type be
    );
        bmwd_word_type res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic bmwd_dword_hit(
        input bmwd_cfg_addr_type addr,
        input bmwd_cfg_addr_type ofs
    );
        return addr[7:2] == ofs[7:2];
    endfunction

endpackage

/* File: rtl/bmwd_window_cmp.sv */
`timescale 1ns/1ps
`default_nettype none

// inclusive range check; a start above the end matches nothing
module bmwd_window_cmp #(
    parameter int W = 64
) (
    input wire logic [W-1:0] lowBound,
    input wire logic [W-1:0] highBound,
    input wire logic [W-1:0] addr,
    output logic hit
);
    assign hit = (addr >= lowBound) && (addr <= highBound);
endmodule

`default_nettype wire

/* File: rtl/bmwd_upper_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module bmwd_upper_reg
    import bmwd_pkg::*;
#(
    parameter bmwd_cfg_addr_type OFS = 8'h00,
    parameter bmwd_word_type RST = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cfgWrEn,
    input wire bmwd_pkg::bmwd_cfg_addr_type cfgAddr,
    input wire bmwd_pkg::bmwd_word_type cfgWrData,
    input wire bmwd_pkg::bmwd_be_type cfgByteEn,
    output bmwd_pkg::bmwd_word_type value
);
    bmwd_word_type value_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            value_r <= RST;
        end else if (cfgWrEn && bmwd_dword_hit(cfgAddr, OFS)) begin
            value_r <= bmwd_merge(value_r, cfgWrData, cfgByteEn);
        end
    end

    assign value = value_r;
endmodule

`default_nettype wire

/* File: tb/bmwd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// upstream software and transaction source; drives only on falling edges
module bmwd_host_model (
    input wire logic clk,
    output logic cfgWrEn,
    output logic cfgRdEn,
    output bmwd_pkg::bmwd_cfg_addr_type cfgAddr,
    output bmwd_pkg::bmwd_word_type cfgWrData,
    output bmwd_pkg::bmwd_be_type cfgByteEn,
    input wire bmwd_pkg::bmwd_word_type cfgRdData,
    input wire logic cfgRdValid,
    output logic txnValid,
    output bmwd_pkg::bmwd_addr_type txnAddr,
    input wire logic fwdValid,
    input wire logic fwdMemHit,
    input wire logic fwdPrefHit
);
    import bmwd_pkg::*;

    initial begin
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
        cfgAddr = 8'h00;
        cfgWrData = 32'h0000_0000;
        cfgByteEn = 4'h0;
        txnValid = 1'b0;
        txnAddr = 64'h0;
    end

    // released data and byte-enable lines are inverted (address is held) so stale values never look right
    task automatic cfgWrite(input bmwd_cfg_addr_type a, input bmwd_word_type d,
            input bmwd_be_type be);
        @(negedge clk);
        cfgAddr = a;
        cfgWrData = d;
        cfgByteEn = be;
        cfgWrEn = 1'b1;
        @(negedge clk);
        cfgWrEn = 1'b0;
        cfgWrData = ~d;
        cfgByteEn = ~be;
    endtask

    // answer is registered: visible half a cycle after the taking edge
    task automatic cfgRead(input bmwd_cfg_addr_type a, output bmwd_word_type d,
            output logic v);
        @(negedge clk);
        cfgAddr = a;
        cfgRdEn = 1'b1;
        @(negedge clk);
        v = cfgRdValid;
        d = cfgRdData;
        cfgRdEn = 1'b0;
        cfgAddr = ~a;
    endtask

    task automatic sendTxn(input bmwd_addr_type a, output logic [2:0] res);
        @(negedge clk);
        txnAddr = a;
        txnValid = 1'b1;
        @(negedge clk);
        res = {fwdValid, fwdMemHit, fwdPrefHit};
        txnValid = 1'b0;
        txnAddr = ~a;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import bmwd_pkg::*;

    logic clk;
    logic rst_b;
    logic cfgWrEn;
    logic cfgRdEn;
    bmwd_cfg_addr_type cfgAddr;
    bmwd_word_type cfgWrData;
    bmwd_be_type cfgByteEn;
    bmwd_word_type cfgRdData;
    logic cfgRdValid;
    logic txnValid;
    bmwd_addr_type txnAddr;
    logic fwdValid;
    logic fwdMemHit;
    logic fwdPrefHit;
    int fails = 0;
    int samplesChecked = 0;
    int cycleCount = 0;
    bmwd_addr_type tAddr [9] = '{64'h0000_0000_1000_0000, 64'h0000_0000_0fff_ffff,
        64'h0000_0000_1fff_ffff, 64'h0000_0000_2000_0000, 64'h0000_0001_1000_0000,
        64'h0000_0001_2000_0000, 64'h0000_0001_1fff_ffff, 64'h0000_0002_300f_ffff,
        64'h0000_0002_3010_0000};
    logic [1:0] tHit [9] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};

    bmwd_top u_bmwd_top (.clk(clk), .rst_b(rst_b), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .txnValid(txnValid),
        .txnAddr(txnAddr), .fwdValid(fwdValid), .fwdMemHit(fwdMemHit),
        .fwdPrefHit(fwdPrefHit));

    bmwd_host_model u_bmwd_host_model (.clk(clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .txnValid(txnValid),
        .txnAddr(txnAddr), .fwdValid(fwdValid), .fwdMemHit(fwdMemHit),
        .fwdPrefHit(fwdPrefHit));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic test_done;
        if (fails == 0 && samplesChecked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdCheck(input bmwd_cfg_addr_type a, input bmwd_word_type exp);
        bmwd_word_type d;
        logic v;
        u_bmwd_host_model.cfgRead(a, d, v);
        check({31'h0, v}, 32'h1);
        check(d, exp);
    endtask

    task automatic txnCheck(input bmwd_addr_type a, input logic [1:0] exp);
        logic [2:0] res;
        u_bmwd_host_model.sendTxn(a, res);
        check({29'h0, res}, {29'h0, 1'b1, exp});
    endtask

    // hang guard: the whole sequence needs well under 200 cycles
    always @(posedge clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 2000) begin
            fails++;
            test_done;
        end
    end

    initial begin
        rst_b = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        rdCheck(8'h20, 32'h0000_0000); // reset image
        rdCheck(8'h24, 32'h0001_0001); // reset image
        rdCheck(8'h28, 32'h0000_0000); // upper start reset
        rdCheck(8'h2c, 32'h0000_0000); // upper end reset
        txnCheck(64'h0000_0000_000f_ffff, 2'h3); // reset windows, top edge
        txnCheck(64'h0000_0000_0010_0000, 2'h0); // one past the top
        u_bmwd_host_model.cfgWrite(8'h20, 32'hffff_ffff, 4'hf);
        rdCheck(8'h20, 32'hfff0_fff0); // fields set, nibbles zero
        u_bmwd_host_model.cfgWrite(8'h24, 32'hffff_fffe, 4'hf);
        rdCheck(8'h24, 32'hfff1_fff1); // fields set, indicator kept
        u_bmwd_host_model.cfgWrite(8'h26, 32'h8880_0000, 4'hc);
        rdCheck(8'h24, 32'h8881_fff1); // end half only
        u_bmwd_host_model.cfgWrite(8'h20, 32'h5550_1230, 4'h3);
        rdCheck(8'h20, 32'hfff0_1230); // low half only
        u_bmwd_host_model.cfgWrite(8'h22, 32'h7ff5_0000, 4'hc);
        rdCheck(8'h20, 32'h7ff0_1230); // end half only, nibble zero
        u_bmwd_host_model.cfgWrite(8'h30, 32'hffff_ffff, 4'hf);
        rdCheck(8'h30, 32'h0000_0000); // unmapped dword
        u_bmwd_host_model.cfgWrite(8'h20, 32'h1ff0_1000, 4'hf);
        u_bmwd_host_model.cfgWrite(8'h24, 32'h3000_2000, 4'hf);
        u_bmwd_host_model.cfgWrite(8'h28, 32'h0000_0001, 4'hf);
        u_bmwd_host_model.cfgWrite(8'h2c, 32'h0000_0002, 4'hf);
        rdCheck(8'h28, 32'h0000_0001); // upper start
        rdCheck(8'h2c, 32'h0000_0002); // upper end
        for (int i = 0; i < 9; i++) begin
            txnCheck(tAddr[i], tHit[i]); // window edges
        end
        u_bmwd_host_model.cfgWrite(8'h20, 32'h0ff0_1000, 4'hf);
        txnCheck(64'h0000_0000_1000_0000, 2'h0); // start above end
        txnCheck(64'h0000_0000_0ff0_0000, 2'h0); // start above end
        @(negedge clk);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        rdCheck(8'h20, 32'h0000_0000); // mid-run reset image
        rdCheck(8'h24, 32'h0001_0001); // mid-run reset image
        rdCheck(8'h28, 32'h0000_0000); // mid-run upper start reset
        rdCheck(8'h2c, 32'h0000_0000); // mid-run upper end reset
        txnCheck(64'h0000_0000_000f_ffff, 2'h3); // reset windows open again
        test_done;
    end
endmodule
`default_nettype wire
